// [logic/aars_consts.vh]
// register offsets, field layouts, reset values and timing counts of the result sequencer
`ifndef AARS_CONSTS_VH
`define AARS_CONSTS_VH
`define AARS_ADDR_W 8
`define AARS_DATA_W 24
`define AARS_CODE_W 22
`define AARS_OFF_SECOND_RES 8'h2a
`define AARS_OFF_SECOND_AMB 8'h2b
`define AARS_OFF_FIRST_RES 8'h2c
`define AARS_OFF_FIRST_AMB 8'h2d
`define AARS_OFF_SECOND_COMB 8'h2e
`define AARS_OFF_FIRST_COMB 8'h2f
`define AARS_OFF_CTRL 8'h30
`define AARS_OFF_CURRENT 8'h31
`define AARS_OFF_STATUS 8'h32
`define AARS_CTRL_TIMER_EN_BIT 0
`define AARS_CTRL_EMIT_ON_BIT 1
`define AARS_CTRL_PUSH_PULL_BIT 2
`define AARS_CTRL_AVG_LSB 8
`define AARS_CTRL_AVG_W 4
`define AARS_AVG_DEFAULT 4'h2
`define AARS_CTRL_RESET 24'h000200
`define AARS_CUR_RED_LSB 0
`define AARS_CUR_IR_LSB 8
`define AARS_CUR_W 8
`define AARS_CUR_RESET 24'h000000
`define AARS_RES_RESET 24'h000000
`define AARS_CONV_TIME_NS 50000
`define AARS_CLK_PERIOD_NS 4
`define AARS_CONV_CYCLES (`AARS_CONV_TIME_NS / `AARS_CLK_PERIOD_NS)
`define AARS_PHASE_AMB2 2'h0
`define AARS_PHASE_IR 2'h1
`define AARS_PHASE_AMB1 2'h2
`define AARS_PHASE_RED 2'h3
`endif

// [logic/aars_averager.v]
// sample accumulator that averages a programmable number of converter samples
`timescale 1ns/1ps
module aars_averager #(
    parameter CODE_W = 22,
    parameter CNT_W = 4
) (
    input wire core_clk, // system clock
    input wire rst, // synchronous reset
    input wire clear, // start a new phase
    input wire sample_valid, // one sample present
    input wire [CODE_W-1:0] sample, // two's complement sample
    input wire [CNT_W-1:0] avg_count, // samples to average
    output reg [CODE_W-1:0] avg_q, // averaged word
    output reg avg_ready_q // average holds a full phase
);
    localparam ACC_W = CODE_W + 16;
    reg [ACC_W-1:0] acc_q;
    reg [CNT_W-1:0] n_q;
    wire [CNT_W-1:0] n_eff = (avg_count == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : avg_count;
    wire [ACC_W-1:0] acc_d = acc_q + {{(ACC_W-CODE_W){sample[CODE_W-1]}}, sample};
    wire signed [ACC_W-1:0] quot = $signed(acc_d) / $signed({{(ACC_W-CNT_W){1'b0}}, n_eff});
    always @(posedge core_clk) begin
        if (rst || clear) begin
            acc_q <= {ACC_W{1'b0}};
            n_q <= {CNT_W{1'b0}};
            avg_ready_q <= 1'b0;
            if (rst)
                avg_q <= {CODE_W{1'b0}};
        end else if (sample_valid && !avg_ready_q) begin
            acc_q <= acc_d;
            n_q <= n_q + 1'b1;
            if (n_q + 1'b1 == n_eff) begin
                avg_q <= quot[CODE_W-1:0];
                avg_ready_q <= 1'b1;
            end
        end
    end
endmodule

// [logic/aars_conv_timer.v]
// converter phase timer: one conversion of fixed length after each reset-pulse fall
`timescale 1ns/1ps
module aars_conv_timer #(
    parameter CONV_CYCLES = 12500,
    parameter CNT_W = 14
) (
    input wire core_clk, // system clock
    input wire rst, // synchronous reset
    input wire start, // falling edge of converter reset
    output reg busy_q, // conversion running
    output reg done_q // one-cycle pulse at end of conversion
);
    reg [CNT_W-1:0] cnt_q;
    always @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= {CNT_W{1'b0}};
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                cnt_q <= CONV_CYCLES[CNT_W-1:0] - 1'b1;
            end else if (busy_q) begin
                if (cnt_q == {CNT_W{1'b0}}) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 1'b1;
                end
            end
        end
    end
endmodule

// [logic/aars_sequencer.v]
// converter result sequencer: averaging, result registers, ready strobe, emitter gating
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "aars_consts.vh"
module aars_sequencer #(
    parameter CONV_CYCLES = `AARS_CONV_CYCLES,
    parameter CODE_W = `AARS_CODE_W,
    parameter AVG_W = `AARS_CTRL_AVG_W
) (
    input wire core_clk, // 250 MHz clock
    input wire rst, // synchronous reset, active high
    input wire [7:0] reg_addr, // register address
    input wire [23:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    output reg [23:0] reg_rdata_q, // read data, cycle after read
    input wire conv_reset, // converter reset pulse from timing engine
    input wire [1:0] conv_phase, // phase slot of this reset pulse
    input wire sample_valid, // converter sample strobe
    input wire [CODE_W-1:0] sample, // converter sample code
    input wire emit_phase, // timing engine wants emitter lit
    input wire ambient_phase, // ambient measurement running
    output reg emitter_on_control_q, // emitter on-control
    output reg push_pull_mode_q, // 1 push-pull, 0 bridge
    output reg [7:0] red_current_q, // red emitter current code
    output reg [7:0] ir_current_q, // infrared emitter current code
    output reg timing_engine_enable_q, // timer enable to timing engine
    output reg conv_busy_q, // conversion in progress
    output reg conv_ready_q // results ready strobe
);
    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    reg [23:0] ctrl_q;
    reg [23:0] current_q;
    always @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= `AARS_CTRL_RESET;
            current_q <= `AARS_CUR_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `AARS_OFF_CTRL)
                ctrl_q <= reg_wdata;
            if (reg_addr == `AARS_OFF_CURRENT)
                current_q <= reg_wdata;
        end
    end
    wire timer_en = ctrl_q[`AARS_CTRL_TIMER_EN_BIT];
    wire emit_en = ctrl_q[`AARS_CTRL_EMIT_ON_BIT];
    wire [AVG_W-1:0] avg_count = ctrl_q[`AARS_CTRL_AVG_LSB +: AVG_W];

    // ------------------------------------------------------------
    // reset pulse edges
    // ------------------------------------------------------------
    reg rst_pulse_q;
    always @(posedge core_clk) begin
        if (rst) begin
            rst_pulse_q <= 1'b0;
        end else begin
            rst_pulse_q <= conv_reset;
        end
    end
    wire reset_rise = conv_reset && !rst_pulse_q && timer_en;
    wire reset_fall = !conv_reset && rst_pulse_q && timer_en;

    // ------------------------------------------------------------
    // conversion timer and averager
    // ------------------------------------------------------------
    wire busy;
    wire conv_done;
    aars_conv_timer #(
        .CONV_CYCLES(CONV_CYCLES),
        .CNT_W(16)
    ) u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(reset_fall),
        .busy_q(busy),
        .done_q(conv_done)
    );
    wire [CODE_W-1:0] avg;
    wire avg_ready;
    aars_averager #(
        .CODE_W(CODE_W),
        .CNT_W(AVG_W)
    ) u_avg (
        .core_clk(core_clk),
        .rst(rst),
        .clear(reset_fall),
        .sample_valid(sample_valid && busy),
        .sample(sample),
        .avg_count(avg_count),
        .avg_q(avg),
        .avg_ready_q(avg_ready)
    );

    // hold the finished average so the next phase cannot disturb it
    reg [CODE_W-1:0] held_q;
    reg held_valid_q;
    always @(posedge core_clk) begin
        if (rst) begin
            held_q <= {CODE_W{1'b0}};
            held_valid_q <= 1'b0;
        end else begin
            if (conv_done && avg_ready) begin
                held_q <= avg;
                held_valid_q <= 1'b1;
            end else if (reset_rise) begin
                held_valid_q <= 1'b0;
            end
        end
    end
    // sign-extend the 22-bit code into the 24-bit word
    wire [23:0] word = {{(24-CODE_W){held_q[CODE_W-1]}}, held_q};

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    // the slot of the rising pulse picks the register, not the slot that started the conversion
    reg [23:0] res_q [0:5];
    reg [5:0] valid_q;
    reg ready_pend_q;
    wire store = reset_rise && held_valid_q;
    integer i;
    always @(posedge core_clk) begin
        if (rst) begin
            for (i = 0; i < 6; i = i + 1)
                res_q[i] <= `AARS_RES_RESET;
            valid_q <= 6'h00;
            ready_pend_q <= 1'b0;
        end else begin
            ready_pend_q <= 1'b0;
            if (store) begin
                case (conv_phase)
                    `AARS_PHASE_AMB2: begin
                        res_q[0] <= word;
                        valid_q[0] <= 1'b1;
                    end
                    `AARS_PHASE_IR: begin
                        res_q[1] <= word;
                        valid_q[1] <= 1'b1;
                    end
                    `AARS_PHASE_AMB1: begin
                        res_q[2] <= word;
                        valid_q[2] <= 1'b1;
                    end
                    `AARS_PHASE_RED: begin
                        res_q[3] <= word;
                        // combined results from the pairs, difference form
                        res_q[4] <= res_q[0] - res_q[1];
                        res_q[5] <= res_q[2] - word;
                        valid_q[5:3] <= 3'h7;
                        ready_pend_q <= &valid_q[2:0];
                    end
                    default: begin
                        valid_q <= valid_q;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            conv_ready_q <= 1'b0;
            conv_busy_q <= 1'b0;
            emitter_on_control_q <= 1'b0;
            push_pull_mode_q <= 1'b0;
            red_current_q <= 8'h00;
            ir_current_q <= 8'h00;
            timing_engine_enable_q <= 1'b0;
        end else begin
            conv_ready_q <= ready_pend_q;
            conv_busy_q <= busy;
            // ambient phase always wins, so no emitter light leaks in
            emitter_on_control_q <= emit_en && timer_en && emit_phase && !ambient_phase;
            push_pull_mode_q <= ctrl_q[`AARS_CTRL_PUSH_PULL_BIT];
            red_current_q <= current_q[`AARS_CUR_RED_LSB +: `AARS_CUR_W];
            ir_current_q <= current_q[`AARS_CUR_IR_LSB +: `AARS_CUR_W];
            timing_engine_enable_q <= timer_en;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    reg [23:0] rd_d;
    always @* begin
        case (reg_addr)
            `AARS_OFF_SECOND_RES: rd_d = res_q[0];
            `AARS_OFF_SECOND_AMB: rd_d = res_q[1];
            `AARS_OFF_FIRST_RES: rd_d = res_q[2];
            `AARS_OFF_FIRST_AMB: rd_d = res_q[3];
            `AARS_OFF_SECOND_COMB: rd_d = res_q[4];
            `AARS_OFF_FIRST_COMB: rd_d = res_q[5];
            `AARS_OFF_CTRL: rd_d = ctrl_q;
            `AARS_OFF_CURRENT: rd_d = current_q;
            `AARS_OFF_STATUS: rd_d = {16'h0000, valid_q, busy, held_valid_q};
            default: rd_d = 24'h000000;
        endcase
    end
    always @(posedge core_clk) begin
        if (rst)
            reg_rdata_q <= 24'h000000;
        else if (reg_rd)
            reg_rdata_q <= rd_d;
        else
            reg_rdata_q <= 24'h000000;
    end
endmodule

// [tb/aars_sequencer_props.sv]
// port checker for the converter result sequencer
`timescale 1ns/1ps
module aars_sequencer_props #(
    parameter CONV_CYCLES = 20
) (
    input wire core_clk, // clock
    input wire rst, // sync reset
    input wire [7:0] reg_addr, // address
    input wire [23:0] reg_wdata, // write data
    input wire reg_wr, // write strobe
    input wire conv_reset, // converter reset pulse
    input wire emit_phase, // emitter wanted
    input wire ambient_phase, // ambient phase
    input wire emitter_on_control_q, // emitter on
    input wire push_pull_mode_q, // drive mode
    input wire [7:0] red_current_q, // red code
    input wire [7:0] ir_current_q, // infrared code
    input wire timing_engine_enable_q, // timer enable
    input wire conv_busy_q, // converting
    input wire conv_ready_q // ready strobe
);
    reg [15:0] busy_n_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // long conversions are measured by a counter, not a repetition
    always @(posedge core_clk) begin
        if (rst || !conv_busy_q) begin
            busy_n_q <= 16'h0000;
        end else begin
            busy_n_q <= busy_n_q + 16'h0001;
        end
    end
    a_conv_start: assert property ($fell(conv_reset) && timing_engine_enable_q |-> ##2 conv_busy_q[*8])
        else $error("conversion did not follow reset pulse fall");
    a_conv_length: assert property ($fell(conv_busy_q) |-> busy_n_q + 1 >= CONV_CYCLES && busy_n_q <= CONV_CYCLES + 1)
        else $error("conversion length wrong");
    a_ready_cause: assert property (conv_ready_q |-> $past(conv_reset, 2) && !$past(conv_reset, 3))
        else $error("ready strobe not two cycles after pulse rise");
    a_ready_single: assert property (conv_ready_q |=> !conv_ready_q[*8])
        else $error("ready strobe longer than one pulse");
    a_ambient_dark: assert property (ambient_phase |=> !emitter_on_control_q)
        else $error("emitter lit in ambient phase");
    a_emit_cause: assert property (emitter_on_control_q |-> $past(emit_phase) && !$past(ambient_phase))
        else $error("emitter lit without request");
    // output copies sit one flop behind the control registers, hence two cycles
    a_current_load: assert property (reg_wr && reg_addr == 8'h31 |-> ##2
        {8'h00, ir_current_q, red_current_q} == ($past(reg_wdata, 2) & 24'h00ffff))
        else $error("current codes not loaded");
    a_mode_load: assert property (reg_wr && reg_addr == 8'h30 |-> ##2
        push_pull_mode_q == |($past(reg_wdata, 2) & 24'h000004))
        else $error("drive mode not loaded");
    a_enable_load: assert property (reg_wr && reg_addr == 8'h30 |-> ##2
        timing_engine_enable_q == |($past(reg_wdata, 2) & 24'h000001))
        else $error("timer enable not loaded");
    c_ready: cover property (conv_ready_q);
    c_emit: cover property (emitter_on_control_q);
    c_start: cover property ($fell(conv_reset) && timing_engine_enable_q);
endmodule
bind aars_sequencer aars_sequencer_props #(.CONV_CYCLES(CONV_CYCLES)) i_aars_sequencer_props (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .conv_reset(conv_reset), .emit_phase(emit_phase), .ambient_phase(ambient_phase),
    .emitter_on_control_q(emitter_on_control_q), .push_pull_mode_q(push_pull_mode_q),
    .red_current_q(red_current_q), .ir_current_q(ir_current_q),
    .timing_engine_enable_q(timing_engine_enable_q), .conv_busy_q(conv_busy_q), .conv_ready_q(conv_ready_q));

// [tb/aars_front_model.sv]
// timing engine and converter stand-in feeding the sequencer
`timescale 1ns/1ps
module aars_front_model #(
    parameter CONV = 20
) (
    input wire core_clk, // clock
    output logic conv_reset, // converter reset pulse
    output logic [1:0] conv_phase, // slot of the pulse
    output logic sample_valid, // sample strobe
    output logic [21:0] sample, // sample code
    output logic emit_phase, // emitter wanted
    output logic ambient_phase // ambient phase
);
    initial begin
        conv_reset = 1'b0;
        conv_phase = 2'h0;
        sample_valid = 1'b0;
        sample = 22'h000000;
        emit_phase = 1'b0;
        ambient_phase = 1'b0;
    end
    task automatic run_phase(input logic [1:0] ph, input logic [21:0] a, input logic [21:0] b);
        @(posedge core_clk);
        conv_reset <= 1'b1;
        conv_phase <= ph;
        repeat (6) @(posedge core_clk);
        conv_reset <= 1'b0;
        conv_phase <= ~ph;
        emit_phase <= !ph[0];
        ambient_phase <= ph[0];
        repeat (2) @(posedge core_clk);
        sample_valid <= 1'b1;
        sample <= a;
        @(posedge core_clk);
        sample <= b;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        sample <= ~b;
        repeat (CONV) @(posedge core_clk);
    endtask
endmodule

// [tb/tb_aars_sequencer.sv]
// self-checking bench for the converter result sequencer
`timescale 1ns/1ps
module tb_aars_sequencer;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [23:0] reg_rdata_q;
    wire conv_reset, sample_valid, emit_phase, ambient_phase;
    wire [1:0] conv_phase;
    wire [21:0] sample;
    wire emitter_on_control_q, push_pull_mode_q, timing_engine_enable_q, conv_busy_q, conv_ready_q;
    wire [7:0] red_current_q, ir_current_q;
    int n_errors = 0;
    int cmp_count = 0;
    int n_ready = 0;
    logic [21:0] sa [4] = '{22'h3ffffd, 22'h200000, 22'h000064, 22'h1fffff};
    logic [21:0] sb [4] = '{22'h3ffffc, 22'h200000, 22'h000033, 22'h1fffff};
    logic [23:0] res [6] = '{24'hfffffd, 24'he00000, 24'h00004b, 24'h1fffff, 24'h1ffffd, 24'he0004c};
    aars_sequencer #(.CONV_CYCLES(20)) i_aars_sequencer (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .conv_reset(conv_reset), .conv_phase(conv_phase), .sample_valid(sample_valid), .sample(sample),
        .emit_phase(emit_phase), .ambient_phase(ambient_phase), .emitter_on_control_q(emitter_on_control_q),
        .push_pull_mode_q(push_pull_mode_q), .red_current_q(red_current_q), .ir_current_q(ir_current_q),
        .timing_engine_enable_q(timing_engine_enable_q), .conv_busy_q(conv_busy_q), .conv_ready_q(conv_ready_q));
    aars_front_model #(.CONV(20)) i_aars_front_model (.core_clk(core_clk), .conv_reset(conv_reset),
        .conv_phase(conv_phase), .sample_valid(sample_valid), .sample(sample), .emit_phase(emit_phase),
        .ambient_phase(ambient_phase));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (conv_ready_q === 1'b1) n_ready <= n_ready + 1;
    end
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // outputs copy the control registers one cycle later
        @(posedge core_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), reg_rdata_q, exp);
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd(8'h30, 24'h000200);
        rd(8'h2e, 24'h000000);
        rd(8'h40, 24'h000000);
        $display("test reset values done");
        wr(8'h31, 24'h00a5c3);
        chk("red", red_current_q, 24'h0000c3);
        chk("ir", ir_current_q, 24'h0000a5);
        wr(8'h30, 24'h000207);
        chk("mode", push_pull_mode_q, 24'h000001);
        wr(8'h30, 24'h000203);
        chk("mode", push_pull_mode_q, 24'h000000);
        chk("timer", timing_engine_enable_q, 24'h000001);
        wr(8'h2a, 24'h123456);
        rd(8'h2a, 24'h000000);
        $display("test registers done");
        // samples of one run land at the next pulse's rise, so the runs start one slot early
        for (int p = 0; p < 4; p++) begin
            i_aars_front_model.run_phase(p[1:0] + 2'h3, sa[p], sb[p]);
            chk("emit", emitter_on_control_q, {23'h000000, p[0]});
        end
        rd(8'h2a, res[0]);
        rd(8'h2e, 24'h000000);
        chk("ready early", n_ready, 24'h000000);
        i_aars_front_model.run_phase(2'h3, sa[0], sb[0]);
        chk("ready", n_ready, 24'h000001);
        for (int i = 0; i < 6; i++) rd(8'h2a + i[7:0], res[i]);
        $display("test result sequence done");
        wr(8'h30, 24'h000000);
        repeat (2) @(posedge core_clk);
        #1;
        chk("emit off", emitter_on_control_q, 24'h000000);
        i_aars_front_model.run_phase(2'h1, sa[1], sb[1]);
        rd(8'h2b, res[1]);
        chk("ready idle", n_ready, 24'h000001);
        $display("test timer off done");
        complete_run;
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        complete_run;
    end
endmodule
